// ==== fesc_cfg.svh ====
// Constants for the flash erase and suspend command block: opcodes, timing and reset values.
// Assumes a 250 MHz pclk shared by the device end and the host end.
`ifndef FESC_CFG_SVH
`define FESC_CFG_SVH

`define FESC_OP_CHIP_ERASE_A  8'h60
`define FESC_OP_CHIP_ERASE_B  8'hc7
`define FESC_OP_RESET_ENABLE  8'h66
`define FESC_OP_RESET         8'h99
`define FESC_OP_LATCH_SET     8'h06
`define FESC_OP_VOL_LATCH_SET 8'h50
`define FESC_OP_LATCH_CLEAR   8'h04
`define FESC_OP_SUSPEND       8'h75
`define FESC_OP_RESUME        8'h7a
`define FESC_OP_QUAD_ENTER    8'h38
`define FESC_OP_STATUS_W1     8'h01
`define FESC_OP_STATUS_W2     8'h31
`define FESC_OP_STATUS_W3     8'h11
`define FESC_OP_SECREG_ERASE  8'h44
`define FESC_OP_SECREG_PROG   8'h42
`define FESC_OP_PAGE_WRITE    8'h02
`define FESC_OP_QPAGE_WRITE   8'h32
`define FESC_OP_SECTOR_CLEAR  8'h20
`define FESC_OP_BLOCK32_CLEAR 8'h52
`define FESC_OP_BLOCK64_CLEAR 8'hd8

`define FESC_CLK_MHZ          250
`define FESC_RESUME_NS        200
`define FESC_SUS_NS           2000
`define FESC_CHIP_ERASE_CYC   32'd100000
`define FESC_ERASE_CYC        32'd20000
`define FESC_PROG_CYC         32'd5000
`define FESC_RST_REC_CYC      32'd8000

`define FESC_PIN_RST          6'h01
`define FESC_WRAP_RST         3'h0
`define FESC_PARAM_RST        8'h00
`define FESC_BIT_LIMIT        5'd16
`define FESC_OPCODE_BITS      5'd8

`define FESC_HOST_HALF_CYC    4'd4
`define FESC_REG_CMD          12'h000
`define FESC_REG_ADDR         12'h004
`define FESC_REG_STAT         12'h008
`define FESC_CMD_QUAD_BIT     8
`define FESC_CMD_NADDR_LSB    9

`endif

// ==== fesc_device.sv ====
// Device end: opcode capture, write latch, chip erase, software reset, suspend and resume, quad entry.
// Assumes the link pins are asynchronous to pclk and each level lasts at least four pclk cycles.
`timescale 1ns/10ps
`include "fesc_cfg.svh"

// Function
// - Chip erase needs write latch set first.
// - Chip erase runs only on exact byte frame.
// - Chip erase starts at select rise, busy flag.
// - Write latch cleared before erase cycle ends.
// - Chip erase ignored when any sector protected.
// - Reset aborts work, clears volatile state.
// - Reset needs enable frame directly before it.
// - Reset recovery interval refuses all commands.
// - Host checks busy, suspend before resetting; fesc_host checks neither, sc_reset only busy.
// - Latch-set opcode sets the write latch.
// - Volatile enable only for next status write.
// - Latch-clear opcode clears the write latch.
// - Latch cleared on completion of writes, erases.
// - Suspend accepted only during program or erase.
// - Suspend sets flag, busy drops within latency.
// - Program suspend rejects writes, erases, programs.
// - Erase suspend rejects status writes, erases.
// - Resume clears suspend, busy returns, finishes.
// - Quad entry only when quad enable set.
// - Quad entry keeps write latch and wrap.
module fesc_device
   import fesc_pkg::*;
#(
   parameter logic [31:0] CHIP_ERASE_CYC = `FESC_CHIP_ERASE_CYC,
   parameter logic [31:0] ERASE_CYC      = `FESC_ERASE_CYC,
   parameter logic [31:0] PROG_CYC       = `FESC_PROG_CYC,
   parameter logic [31:0] RST_REC_CYC    = `FESC_RST_REC_CYC
) (
   input  wire logic       pclk,
   input  wire logic       presetn,
   fesc_link_if.dev        link,
   input  wire logic       quad_enable_bit,
   input  wire logic       sector_protected,
   input  wire logic [1:0] err_set,
   output logic            write_enable_latch,
   output logic            write_in_progress,
   output logic            suspend_flag,
   output logic            four_bit_command_mode,
   output logic [1:0]      err_flags,
   output logic [7:0]      read_param_field,
   output logic [2:0]      wrap_field,
   output logic            cmd_strobe,
   output logic [7:0]      cmd_code,
   output logic            status_write_volatile
);
   localparam logic [31:0] RESUME_CYC = 32'((`FESC_RESUME_NS * `FESC_CLK_MHZ) / 1000);
   localparam logic [31:0] SUS_CYC    = 32'((`FESC_SUS_NS * `FESC_CLK_MHZ) / 1000);

   logic [5:0]     sync1, sync2, sync3, pin, pin_prev;
   logic [7:0]     shreg;
   logic [4:0]     bits;
   logic           rst_armed, vol_en, op_prog, op_chip;
   logic [31:0]    opcnt, dly, next_opcnt, next_dly;
   fesc_op_state_t state, next_state;

   // Pins: bit 0 select, bit 1 clock, bits 5:2 data; a level counts once stages two and three agree.
   wire [5:0] pin_raw    = {link.sdi, link.sclk, link.cs_n};
   wire [5:0] next_pin   = (sync2 & sync3) | (pin & (sync2 ^ sync3));
   wire       cs_fall    = pin_prev[0] & ~pin[0];
   wire       cs_rise    = ~pin_prev[0] & pin[0];
   wire       sclk_rise  = ~pin_prev[1] & pin[1] & ~pin[0];
   wire [4:0] step       = four_bit_command_mode ? 5'd4 : 5'd1;
   wire [7:0] shifted    = four_bit_command_mode ? {shreg[3:0], pin[5:2]} : {shreg[6:0], pin[2]};

   wire [7:0] op         = shreg;
   wire       has_op     = bits >= `FESC_OPCODE_BITS;
   wire       exact      = bits == `FESC_OPCODE_BITS;
   wire       idle       = state == FESC_IDLE;
   wire       suspended  = state == FESC_SUSPENDED;
   wire       open_state = idle | suspended;
   wire       frame_done = cs_rise & has_op & (state != FESC_RECOVER);

   wire is_ce   = (op == `FESC_OP_CHIP_ERASE_A) | (op == `FESC_OP_CHIP_ERASE_B);
   wire is_pgm  = (op == `FESC_OP_PAGE_WRITE) | (op == `FESC_OP_QPAGE_WRITE);
   wire is_ers  = (op == `FESC_OP_SECTOR_CLEAR) | (op == `FESC_OP_BLOCK32_CLEAR) |
                  (op == `FESC_OP_BLOCK64_CLEAR);
   wire is_srw  = (op == `FESC_OP_STATUS_W1) | (op == `FESC_OP_STATUS_W2) | (op == `FESC_OP_STATUS_W3);
   wire is_misc = (op == `FESC_OP_RESET_ENABLE) | (op == `FESC_OP_RESET) | (op == `FESC_OP_LATCH_SET) |
                  (op == `FESC_OP_VOL_LATCH_SET) | (op == `FESC_OP_LATCH_CLEAR) |
                  (op == `FESC_OP_SUSPEND) | (op == `FESC_OP_RESUME) | (op == `FESC_OP_QUAD_ENTER);

   // Commands refused while an operation sits suspended.
   wire blk_susp = suspended & (is_srw | (op == `FESC_OP_SECREG_ERASE) | is_ers | is_ce |
                   (op_prog & (is_pgm | (op == `FESC_OP_SECREG_PROG))));

   wire rst_go   = frame_done & exact & (op == `FESC_OP_RESET) & rst_armed;
   wire write_latch_set_cmd_ok  = frame_done & exact & (op == `FESC_OP_LATCH_SET) & open_state;
   wire write_latch_clear_cmd_ok  = frame_done & exact & (op == `FESC_OP_LATCH_CLEAR) & open_state;
   wire vwren_ok = frame_done & exact & (op == `FESC_OP_VOL_LATCH_SET) & open_state;
   wire ce_ok    = frame_done & exact & is_ce & write_enable_latch & idle & ~sector_protected;
   wire pe_ok    = frame_done & (is_pgm | is_ers) & write_enable_latch & idle;
   wire srw_ok   = frame_done & is_srw & (write_enable_latch | vol_en) & open_state & ~blk_susp;
   wire susp_ok  = frame_done & exact & (op == `FESC_OP_SUSPEND) & (state == FESC_RUN) &
                   ~op_chip & ~suspend_flag & write_in_progress;
   wire res_ok   = frame_done & exact & (op == `FESC_OP_RESUME) & suspended &
                   suspend_flag & ~write_in_progress;
   wire qpi_ok   = frame_done & exact & (op == `FESC_OP_QUAD_ENTER) & open_state & quad_enable_bit;
   wire pass_ok  = frame_done & open_state & ~blk_susp & ~(is_ce | is_pgm | is_ers | is_srw | is_misc);
   wire accepted = write_latch_set_cmd_ok | write_latch_clear_cmd_ok | vwren_ok | ce_ok | pe_ok | srw_ok | susp_ok | res_ok |
                   qpi_ok | rst_go | pass_ok;

   always_comb begin
      next_state = state;
      next_opcnt = opcnt;
      next_dly   = dly;
      case (state)
         FESC_IDLE: begin
            if (ce_ok | pe_ok) begin
               next_state = FESC_RUN;
               next_opcnt = ce_ok ? CHIP_ERASE_CYC : (is_pgm ? PROG_CYC : ERASE_CYC);
            end
         end
         FESC_RUN: begin
            if (susp_ok) begin
               next_state = FESC_SUSPENDING;
               next_dly   = SUS_CYC;
            end else if (opcnt <= 32'd1) begin
               next_state = FESC_IDLE;
               next_opcnt = 32'd0;
            end else begin
               next_opcnt = opcnt - 32'd1;
            end
         end
         FESC_SUSPENDING: begin
            if (dly <= 32'd1) begin
               next_state = FESC_SUSPENDED;
            end else begin
               next_dly = dly - 32'd1;
            end
         end
         FESC_SUSPENDED: begin
            if (res_ok) begin
               next_state = FESC_RESUMING;
               next_dly   = RESUME_CYC;
            end
         end
         FESC_RESUMING, FESC_RECOVER: begin
            if (dly <= 32'd1) begin
               next_state = (state == FESC_RESUMING) ? FESC_RUN : FESC_IDLE;
            end else begin
               next_dly = dly - 32'd1;
            end
         end
         default: begin
            next_state = FESC_IDLE;
         end
      endcase
      if (rst_go) begin
         next_state = FESC_RECOVER;
         next_opcnt = 32'd0;
         next_dly   = RST_REC_CYC;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1    <= `FESC_PIN_RST;
         sync2    <= `FESC_PIN_RST;
         sync3    <= `FESC_PIN_RST;
         pin      <= `FESC_PIN_RST;
         pin_prev <= `FESC_PIN_RST;
      end else begin
         sync1    <= pin_raw;
         sync2    <= sync1;
         sync3    <= sync2;
         pin      <= next_pin;
         pin_prev <= pin;
      end
   end

   // Only the opcode byte is kept; address and data bits that follow just saturate the count.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shreg <= 8'h00;
         bits  <= 5'h00;
      end else if (cs_fall) begin
         shreg <= 8'h00;
         bits  <= 5'h00;
      end else if (sclk_rise && bits < `FESC_BIT_LIMIT) begin
         if (bits < `FESC_OPCODE_BITS) begin
            shreg <= shifted;
         end
         bits <= bits + step;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state     <= FESC_IDLE;
         opcnt     <= 32'h0;
         dly       <= 32'h0;
         op_prog   <= 1'b0;
         op_chip   <= 1'b0;
         rst_armed <= 1'b0;
         vol_en    <= 1'b0;
      end else begin
         state <= next_state;
         opcnt <= next_opcnt;
         dly   <= next_dly;
         if (ce_ok | pe_ok) begin
            op_prog <= is_pgm;
            op_chip <= ce_ok;
         end
         if (frame_done) begin
            rst_armed <= exact & (op == `FESC_OP_RESET_ENABLE);
            vol_en    <= vwren_ok;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         write_enable_latch    <= 1'b0;
         write_in_progress     <= 1'b0;
         suspend_flag          <= 1'b0;
         four_bit_command_mode <= 1'b0;
         err_flags             <= 2'h0;
         read_param_field      <= `FESC_PARAM_RST;
         wrap_field            <= `FESC_WRAP_RST;
         cmd_strobe            <= 1'b0;
         cmd_code              <= 8'h00;
         status_write_volatile <= 1'b0;
      end else begin
         if (rst_go) begin
            write_enable_latch <= 1'b0;
         end else if (state == FESC_RUN && opcnt == 32'd2) begin
            write_enable_latch <= 1'b0;
         end else if (write_latch_set_cmd_ok) begin
            write_enable_latch <= 1'b1;
         end else if (write_latch_clear_cmd_ok || (srw_ok && !vol_en)) begin
            write_enable_latch <= 1'b0;
         end
         write_in_progress <= (next_state == FESC_RUN) | (next_state == FESC_SUSPENDING) |
                              (next_state == FESC_RECOVER);
         suspend_flag      <= (next_state == FESC_SUSPENDING) | (next_state == FESC_SUSPENDED);
         if (rst_go) begin
            four_bit_command_mode <= 1'b0;
         end else if (qpi_ok) begin
            four_bit_command_mode <= 1'b1;
         end
         // Error flags are set by the array; a set in the reset cycle still lands.
         err_flags <= (rst_go ? 2'h0 : err_flags) | err_set;
         if (rst_go) begin
            read_param_field <= `FESC_PARAM_RST;
            wrap_field       <= `FESC_WRAP_RST;
         end
         cmd_strobe            <= accepted;
         cmd_code              <= op;
         status_write_volatile <= srw_ok & vol_en;
      end
   end
endmodule : fesc_device

// ==== fesc_host.sv ====
// Host end: APB-programmed controller that sends one opcode frame, with optional address bytes.
// Assumes the device end samples the link through a synchroniser; half clock period is four pclk cycles.
`timescale 1ns/10ps
`include "fesc_cfg.svh"

module fesc_host
   import fesc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   fesc_link_if.host        link
);
   fesc_host_state_t state;
   logic [31:0]      shreg;
   logic [5:0]       remain;
   logic [3:0]       tm;
   logic             quad;
   logic [23:0]      addr;
   logic             cs_n, sclk;
   logic [3:0]       sdi;

   wire       access   = psel & penable & ~pready;
   wire       commit   = psel & penable & pready & pwrite;
   wire       hit_cmd  = paddr == `FESC_REG_CMD;
   wire       hit_addr = paddr == `FESC_REG_ADDR;
   wire       hit_stat = paddr == `FESC_REG_STAT;
   wire       busy     = state != FESC_H_IDLE;
   // A command write while a frame is in flight is refused rather than queued.
   wire       bad      = ~(hit_cmd | hit_addr | hit_stat) | (pwrite & hit_cmd & busy);
   wire       go       = commit & hit_cmd & ~busy;
   wire [1:0] naddr    = pwdata[`FESC_CMD_NADDR_LSB +: 2];
   wire       go_quad  = pwdata[`FESC_CMD_QUAD_BIT];
   wire [31:0] go_data = {pwdata[7:0], addr};
   wire [31:0] shifted = quad ? {shreg[27:0], 4'h0} : {shreg[30:0], 1'b0};
   wire [5:0] step     = quad ? 6'd4 : 6'd1;
   wire [5:0] left     = remain - step;
   wire       tm_end   = tm == (`FESC_HOST_HALF_CYC - 4'd1);
   wire [31:0] rd_mux  = hit_addr ? {8'h00, addr} : (hit_stat ? {31'h0, busy} : 32'h0);

   assign link.cs_n = cs_n;
   assign link.sclk = sclk;
   assign link.sdi  = sdi;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
         addr    <= 24'h0;
      end else begin
         pready <= access;
         if (access) begin
            pslverr <= bad;
            prdata  <= pwrite ? 32'h0 : rd_mux;
         end
         if (commit && hit_addr) begin
            addr <= pwdata[23:0];
         end
      end
   end

   // Data changes while the clock is low and holds through the high half, MSB first.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state  <= FESC_H_IDLE;
         shreg  <= 32'h0;
         remain <= 6'h0;
         tm     <= 4'h0;
         quad   <= 1'b0;
         cs_n   <= 1'b1;
         sclk   <= 1'b0;
         sdi    <= 4'h0;
      end else begin
         tm <= tm_end ? 4'h0 : tm + 4'd1;
         case (state)
            FESC_H_IDLE: begin
               tm <= 4'h0;
               if (go) begin
                  state  <= FESC_H_LOW;
                  shreg  <= go_data;
                  remain <= 6'd8 + {1'b0, naddr, 3'b000};
                  quad   <= go_quad;
                  cs_n   <= 1'b0;
                  sdi    <= go_quad ? pwdata[7:4] : {3'b000, pwdata[7]};
               end
            end
            FESC_H_LOW: begin
               if (tm_end) begin
                  state <= FESC_H_HIGH;
                  sclk  <= 1'b1;
               end
            end
            FESC_H_HIGH: begin
               if (tm_end) begin
                  sclk   <= 1'b0;
                  shreg  <= shifted;
                  remain <= left;
                  sdi    <= quad ? shifted[31:28] : {3'b000, shifted[31]};
                  if (left == 6'd0) begin
                     state <= FESC_H_END;
                     cs_n  <= 1'b1;
                  end else begin
                     state <= FESC_H_LOW;
                  end
               end
            end
            FESC_H_END: begin
               sdi <= 4'h0;
               if (tm_end) begin
                  state <= FESC_H_IDLE;
               end
            end
            default: begin
               state <= FESC_H_IDLE;
               cs_n  <= 1'b1;
               sclk  <= 1'b0;
            end
         endcase
      end
   end
endmodule : fesc_host

// ==== fesc_link_if.sv ====
// Serial command link between the host controller and the flash device end.
// Assumes the testbench instantiates it and hands one modport to each end.
`timescale 1ns/10ps
interface fesc_link_if;
   logic       cs_n;
   logic       sclk;
   logic [3:0] sdi;
   modport host (output cs_n, output sclk, output sdi);
   modport dev  (input cs_n, input sclk, input sdi);
endinterface : fesc_link_if

// ==== fesc_pkg.sv ====
// Types shared by both ends of the flash erase and suspend command link.
// Assumes fesc_cfg.svh supplies the numeric constants.
package fesc_pkg;
   typedef enum logic [2:0] {
      FESC_IDLE       = 3'b000,
      FESC_RUN        = 3'b001,
      FESC_SUSPENDING = 3'b011,
      FESC_SUSPENDED  = 3'b010,
      FESC_RESUMING   = 3'b110,
      FESC_RECOVER    = 3'b100
   } fesc_op_state_t;

   typedef enum logic [1:0] {
      FESC_H_IDLE = 2'b00,
      FESC_H_LOW  = 2'b01,
      FESC_H_HIGH = 2'b11,
      FESC_H_END  = 2'b10
   } fesc_host_state_t;
endpackage : fesc_pkg

// ==== fesc_sva.sv ====
// Checker for the command link and the flags of the device end.
// Assumes one pclk for both ends and link pins that change only on pclk edges.
`timescale 1ns/10ps
`include "fesc_cfg.svh"
module fesc_sva (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       cs_n,
   input wire logic       sclk,
   input wire logic [3:0] sdi,
   input wire logic       quad_enable_bit,
   input wire logic       write_enable_latch,
   input wire logic       write_in_progress,
   input wire logic       suspend_flag,
   input wire logic       four_bit_command_mode,
   input wire logic       cmd_strobe,
   input wire logic [7:0] cmd_code,
   input wire logic [2:0] wrap_field
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_sclk_in_frame: assert property ($rose(sclk) |-> !cs_n)
      else $error("link clock rose outside a frame");
   chk_data_held_high: assert property (sclk |-> $stable(sdi))
      else $error("link data moved while clock high");
   chk_latch_set_cmd: assert property (cmd_strobe && cmd_code == `FESC_OP_LATCH_SET && !write_in_progress
      |-> ##[0:2] write_enable_latch) else $error("latch not set by set command");
   chk_latch_clr_cmd: assert property (cmd_strobe && cmd_code == `FESC_OP_LATCH_CLEAR
      |-> ##[0:2] !write_enable_latch) else $error("latch not cleared by clear command");
   chk_susp_needs_busy: assert property ($rose(suspend_flag) |-> $past(write_in_progress))
      else $error("suspend taken while idle");
   chk_susp_latency: assert property ($rose(suspend_flag) |-> ##[0:500] !write_in_progress)
      else $error("busy still high after suspend latency");
   chk_resume_busy: assert property ($fell(suspend_flag) |-> ##[0:52] write_in_progress)
      else $error("busy not back after resume");
   chk_quad_needs_qe: assert property ($rose(four_bit_command_mode) |-> quad_enable_bit)
      else $error("quad mode entered without quad enable");
   chk_quad_keeps_state: assert property ($rose(four_bit_command_mode)
      |-> $stable(write_enable_latch) && $stable(wrap_field)) else $error("quad entry changed latch or wrap");
   chk_latch_before_done: assert property ($fell(write_in_progress) && !suspend_flag
      |-> !write_enable_latch) else $error("latch still set at end of operation");
endmodule : fesc_sva

// ==== tb_flash_erase_suspend_control.sv ====
// Testbench joining host and device ends over the link, with software access over APB.
// Assumes shortened device counts; flags are read straight from the device ports.
`timescale 1ns/10ps
module tb_flash_erase_suspend_control;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic        quad_enable_bit = 1'b0;
   logic        sector_protected = 1'b0;
   logic [1:0]  err_set = 2'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, er, write_enable_latch, write_in_progress, suspend_flag;
   logic        four_bit_command_mode, cmd_strobe, status_write_volatile;
   logic [7:0]  cmd_code, read_param_field;
   logic [7:0]  sh1 = 8'h00;
   logic [7:0]  sh4 = 8'h00;
   logic [2:0]  wrap_field;
   logic [1:0]  err_flags;
   int          fails = 0;
   int          tests_run = 0;
   int          vol_cnt = 0;
   int          stb_cnt = 0;
   fesc_link_if link ();
   fesc_host i_fesc_host (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .link(link.host));
   fesc_device #(.CHIP_ERASE_CYC(32'd400), .ERASE_CYC(32'd2000), .PROG_CYC(32'd600), .RST_REC_CYC(32'd300))
      i_fesc_device (.pclk, .presetn, .link(link.dev), .quad_enable_bit, .sector_protected, .err_set,
      .write_enable_latch, .write_in_progress, .suspend_flag, .four_bit_command_mode, .err_flags,
      .read_param_field, .wrap_field, .cmd_strobe, .cmd_code, .status_write_volatile);
   fesc_sva i_fesc_sva (.pclk, .presetn, .cs_n(link.cs_n), .sclk(link.sclk), .sdi(link.sdi), .quad_enable_bit,
      .write_enable_latch, .write_in_progress, .suspend_flag, .four_bit_command_mode, .cmd_strobe,
      .cmd_code, .wrap_field);
   initial begin
      forever #2 pclk = ~pclk;
   end
   // Sniffers keep the last byte clocked in a frame from the wire, opcode or address, one lane and four lanes.
   always @(posedge link.sclk) begin
      if (!link.cs_n) begin
         sh1 <= {sh1[6:0], link.sdi[0]};
         sh4 <= {sh4[3:0], link.sdi};
      end
   end
   always @(posedge pclk) begin
      if (status_write_volatile === 1'b1) vol_cnt <= vol_cnt + 1;
      if (cmd_strobe === 1'b1) stb_cnt <= stb_cnt + 1;
   end
   task complete_run;
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : complete_run
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task bound(input int n, input int lim);
      if (n >= lim) begin
         fails++;
         complete_run();
      end
   endtask : bound
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      bound(n, 20);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // Mode: bit 0 selects four lanes, bits 2:1 give the address bytes after the opcode.
   task send(input logic [7:0] op, input logic [2:0] mode);
      int n;
      apb(1'b1, 12'h000, {21'h000000, mode, op});
      n = 0;
      do begin
         apb(1'b0, 12'h008, 32'h00000000);
         n++;
      end while (rd[0] !== 1'b0 && n < 100);
      bound(n, 100);
      repeat (12) @(posedge pclk);
   endtask : send
   task wait_wip(input logic v, input int lim);
      int n;
      n = 0;
      while (write_in_progress !== v && n < lim) begin
         @(posedge pclk);
         n++;
      end
      bound(n, lim);
   endtask : wait_wip
   task sc_apb;
      apb(1'b0, 12'h00c, 32'h00000000);
      cmp(er, 1'b1);
      cmp(rd, 32'h00000000);
      apb(1'b1, 12'h004, 32'h00a5c3e1);
      apb(1'b0, 12'h004, 32'h00000000);
      cmp(er, 1'b0);
      cmp(rd, 32'h00a5c3e1);
   endtask : sc_apb
   task sc_latch;
      send(8'h06, 3'h0);
      cmp(write_enable_latch, 1'b1);
      cmp(sh1, 8'h06);
      cmp(link.cs_n, 1'b1);
      send(8'h04, 3'h0);
      cmp(write_enable_latch, 1'b0);
   endtask : sc_latch
   task sc_erase;
      send(8'h60, 3'h0);
      cmp(write_in_progress, 1'b0);
      send(8'h06, 3'h0);
      sector_protected <= 1'b1;
      send(8'hc7, 3'h0);
      cmp(write_in_progress, 1'b0);
      sector_protected <= 1'b0;
      send(8'h60, 3'h2);
      cmp(write_in_progress, 1'b0);
      send(8'h06, 3'h0);
      send(8'hc7, 3'h0);
      cmp(write_in_progress, 1'b1);
      send(8'h75, 3'h0);
      cmp(suspend_flag, 1'b0);
      wait_wip(1'b0, 600);
      cmp(write_enable_latch, 1'b0);
   endtask : sc_erase
   task sc_suspend;
      int c0;
      send(8'h75, 3'h0);
      cmp(suspend_flag, 1'b0);
      send(8'h06, 3'h0);
      send(8'h20, 3'h6);
      send(8'h75, 3'h0);
      cmp(suspend_flag, 1'b1);
      wait_wip(1'b0, 600);
      send(8'h06, 3'h0);
      send(8'h20, 3'h6);
      cmp(write_in_progress, 1'b0);
      c0 = stb_cnt;
      send(8'h44, 3'h6);
      send(8'h42, 3'h6);
      cmp(stb_cnt - c0, 32'd1);
      send(8'h7a, 3'h0);
      cmp(suspend_flag, 1'b0);
      wait_wip(1'b1, 60);
      wait_wip(1'b0, 3000);
      cmp(write_enable_latch, 1'b0);
   endtask : sc_suspend
   // A suspended program refuses the security-register program that an erase suspend lets through.
   task sc_prog;
      int c0;
      send(8'h06, 3'h0);
      send(8'h02, 3'h6);
      cmp(write_in_progress, 1'b1);
      send(8'h75, 3'h0);
      cmp(suspend_flag, 1'b1);
      wait_wip(1'b0, 600);
      c0 = stb_cnt;
      send(8'h42, 3'h6);
      send(8'h02, 3'h6);
      cmp(stb_cnt - c0, 32'd0);
      send(8'h7a, 3'h0);
      wait_wip(1'b1, 60);
      wait_wip(1'b0, 700);
      cmp(write_enable_latch, 1'b0);
   endtask : sc_prog
   task sc_vol;
      int c0;
      c0 = vol_cnt;
      send(8'h50, 3'h0);
      send(8'h01, 3'h2);
      cmp(vol_cnt - c0, 32'd1);
      send(8'h50, 3'h0);
      send(8'h06, 3'h0);
      send(8'h01, 3'h2);
      cmp(vol_cnt - c0, 32'd1);
   endtask : sc_vol
   task sc_reset;
      err_set <= 2'h3;
      @(posedge pclk);
      err_set <= 2'h0;
      cmp(write_in_progress, 1'b0);
      send(8'h66, 3'h0);
      send(8'h06, 3'h0);
      send(8'h99, 3'h0);
      cmp(err_flags, 2'h3);
      send(8'h66, 3'h0);
      send(8'h99, 3'h0);
      cmp(err_flags, 2'h0);
      cmp(write_enable_latch, 1'b0);
      cmp(read_param_field, 8'h00);
      cmp(write_in_progress, 1'b1);
      send(8'h06, 3'h0);
      cmp(write_enable_latch, 1'b0);
      wait_wip(1'b0, 400);
   endtask : sc_reset
   task sc_quad;
      send(8'h38, 3'h0);
      cmp(four_bit_command_mode, 1'b0);
      quad_enable_bit <= 1'b1;
      send(8'h06, 3'h0);
      send(8'h38, 3'h0);
      cmp(four_bit_command_mode, 1'b1);
      cmp(write_enable_latch, 1'b1);
      cmp(wrap_field, 3'h0);
      send(8'h04, 3'h1);
      cmp(write_enable_latch, 1'b0);
      cmp(sh4, 8'h04);
   endtask : sc_quad
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      cmp(write_enable_latch, 1'b0);
      sc_apb();
      sc_latch();
      sc_erase();
      sc_suspend();
      sc_prog();
      sc_vol();
      sc_reset();
      sc_quad();
      complete_run();
   end
endmodule : tb_flash_erase_suspend_control
